// *** mexec_params.svh ***
// constants for the instruction execution and timing block
`ifndef MEXEC_PARAMS_SVH
`define MEXEC_PARAMS_SVH

`define MEXEC_OP_W        5
`define MEXEC_DATA_W      8
`define MEXEC_ADDR_W      7
`define MEXEC_PC_W        11
`define MEXEC_PC_LOW_ADDR 7'h02
`define MEXEC_TBL_LAST_PG 3'h7
`define MEXEC_CYC_ONE     2'h1
`define MEXEC_CYC_TWO     2'h2
`define MEXEC_HALF_BIT    3
`define MEXEC_SIGN_BIT    7
`define MEXEC_BYTE_ZERO   8'h00
`define MEXEC_BYTE_ONE    8'h01
`define MEXEC_ACC_RST     8'h00
`define MEXEC_TH_RST      8'h00

`endif

// *** mexec_pkg.sv ***
// types for the instruction execution and timing block
package mexec_pkg;

	typedef enum logic [4:0] {
		op_nop,
		increment_to_accumulator,
		increment_to_mem,
		decrement_to_accumulator,
		decrement_to_mem,
		rotate_right_to_accum,
		rotate_right_to_mem,
		rotate_right_thru_spill_accum,
		rotate_right_thru_spill,
		rotate_left_to_accum,
		rotate_left_to_mem,
		rotate_left_thru_spill_accum,
		rotate_left_thru_spill,
		move_mem_to_accum,
		move_accum_to_mem,
		move_imm_to_accum,
		bit_clear,
		bit_set,
		skip_if_null,
		skip_null_copy_accum,
		skip_if_bit_clear,
		skip_if_bit_set,
		inc_skip_if_null,
		dec_skip_if_null,
		inc_skip_null_accum,
		dec_skip_null_accum,
		jump_direct,
		call_sub,
		ret_sub,
		ret_load_imm,
		return_from_irq,
		op_misc
	} mexec_op_t;

	// sub-codes of op_misc
	typedef enum logic [3:0] {
		misc_lookup_read_cur_page,
		misc_lookup_read_last_page,
		misc_nibble_exchange_mem,
		misc_nibble_exchange_accum,
		misc_watchdog_clear,
		misc_watchdog_preclear_first,
		misc_watchdog_preclear_second,
		misc_power_down,
		misc_add_with_spill_to_accum,
		misc_add_with_spill_to_mem,
		misc_add_to_accum,
		misc_add_to_mem,
		misc_add_imm,
		misc_bitwise_and_to_accum,
		misc_bitwise_and_to_mem,
		misc_bitwise_and_imm
	} mexec_misc_t;

	typedef struct packed {
		mexec_op_t   op;
		mexec_misc_t misc;
		logic [2:0]  bit_sel;
		logic [6:0]  mem_addr;
		logic [7:0]  imm;
	} mexec_instr_t;

	typedef struct packed {
		logic signed_range_flag;
		logic half_spill_bit;
		logic spill;
		logic null_flag;
	} mexec_flags_t;

	typedef struct packed {
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} mexec_mem_wr_t;

endpackage

// *** mexec_alu.sv ***
// adder and logic datapath of the execution block
`timescale 1ns/1ps
`include "mexec_params.svh"

module mexec_alu (
	// operands
	input  wire logic [7:0]         a_in,
	input  wire logic [7:0]         b_in,
	input  wire logic               cin_in,
	input  wire logic               and_sel_in,
	// result and flags
	output logic [7:0]              res_out,
	output mexec_pkg::mexec_flags_t flags_out
);

	logic [4:0] lo_sum;
	logic [4:0] hi_sum;

	always_comb begin
		lo_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
		hi_sum = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, lo_sum[4]};
		if (and_sel_in) begin
			res_out = a_in & b_in;
		end else begin
			res_out = {hi_sum[3:0], lo_sum[3:0]};
		end
		flags_out.null_flag         = (res_out == `MEXEC_BYTE_ZERO);
		flags_out.spill             = hi_sum[4];
		flags_out.half_spill_bit    = lo_sum[4];
		flags_out.signed_range_flag = (a_in[`MEXEC_SIGN_BIT] == b_in[`MEXEC_SIGN_BIT])
			&& (res_out[`MEXEC_SIGN_BIT] != a_in[`MEXEC_SIGN_BIT]);
	end

endmodule

// *** mexec_core.sv ***
// instruction execution, cycle timing and status flags of the 8-bit core
// Function
// - inc/dec memory byte to byte or accumulator; null flag only; accumulator form one cycle
// - plain rotates change no flags; rotates through spill change only spill
// - moves change no flags; moves into accumulator take one cycle
// - bit clear/set change only the addressed bit, no flags
// - jump, call, returns take two cycles, no flags
// - skip takes two cycles when skipping, one otherwise
// - skip on zero byte, bit zero, bit one; inc/dec skip test result
// - accumulator skip forms load accumulator and skip on that value
// - any write to program counter low byte takes two cycles
// - paired pre-clears clear watchdog flags only when run back to back
// - power-down and watchdog clears take one cycle, touch both flags
// - table reads put high part in lookup high, low in memory, two cycles
// - nibble exchange to byte or accumulator, no flags, accumulator one cycle
// - add with spill sums accumulator, byte, spill; updates four flags
// - add sums accumulator and byte into either; updates four flags
// - add immediate sums into accumulator; updates four flags
// - logical and to accumulator or byte; null flag only
// - power-down stops execution, clears watchdog, sets sleep flag, clears expiry
// - watchdog clear clears counter and both flags unconditionally
`timescale 1ns/1ps
`include "mexec_params.svh"

module mexec_core (
	// clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     rst_in,
	// instruction issue
	input  wire logic                     instr_valid_in,
	input  mexec_pkg::mexec_instr_t       instr_in,
	output logic                          instr_ready_out,
	// data memory ports
	output logic [6:0]                    mem_raddr_out,
	input  wire logic [7:0]               mem_rdata_in,
	output mexec_pkg::mexec_mem_wr_t      mem_wr_out,
	// program memory for table reads
	input  wire logic [10:0]              pc_in,
	input  wire logic [7:0]               tbl_ptr_in,
	output logic [10:0]                   prog_addr_out,
	input  wire logic [15:0]              prog_data_in,
	// watchdog expiry
	input  wire logic                     wdt_expire_in,
	// status
	output logic [7:0]                    acc_out,
	output logic [7:0]                    lookup_high_byte_out,
	output mexec_pkg::mexec_flags_t       flags_out,
	output logic                          wdt_expired_flag_out,
	output logic                          sleep_entered_flag_out,
	output logic                          wdt_clear_out,
	output logic                          power_down_out,
	output logic                          skip_next_out,
	output logic                          pc_load_out
);

	typedef enum logic [1:0] {
		st_run,
		st_second,
		st_halted
	} mexec_state_t;

	mexec_state_t            state_q, state_d;
	logic [7:0]              acc_q, acc_d;
	logic [7:0]              th_q, th_d;
	mexec_pkg::mexec_flags_t fl_q, fl_d;
	logic                    to_q, to_d, pd_q, pd_d;
	logic                    pre1_q, pre1_d, pre2_q, pre2_d;
	mexec_pkg::mexec_mem_wr_t wr_q, wr_d;
	logic                    wdc_q, wdc_d, pdn_q, pdn_d, skip_q, skip_d, pcl_q, pcl_d;
	mexec_pkg::mexec_instr_t ins_q, ins_d;

	logic [7:0]              m;
	logic [7:0]              b_op;
	logic                    cin;
	logic                    and_sel;
	logic [7:0]              alu_res;
	mexec_pkg::mexec_flags_t alu_fl;
	logic                    wr_acc, wr_mem;
	logic [7:0]              res;
	logic                    take_issue;
	logic                    wdt_sync1_q, wdt_sync2_q, wdt_prev_q;

	// ************************************************
	// datapath
	// ************************************************
	mexec_alu u_alu (
		.a_in       (acc_q),
		.b_in       (b_op),
		.cin_in     (cin),
		.and_sel_in (and_sel),
		.res_out    (alu_res),
		.flags_out  (alu_fl)
	);

	assign m               = mem_rdata_in;
	assign mem_raddr_out   = instr_in.mem_addr;
	assign instr_ready_out = (state_q == st_run);
	assign take_issue      = instr_valid_in && (state_q == st_run);
	// table word: current page keeps pc high bits, last page is fixed
	assign prog_addr_out   = (instr_in.misc == mexec_pkg::misc_lookup_read_last_page) ?
		{`MEXEC_TBL_LAST_PG, tbl_ptr_in} : {pc_in[10:8], tbl_ptr_in};

	always_comb begin
		b_op    = (instr_in.misc == mexec_pkg::misc_add_imm ||
			instr_in.misc == mexec_pkg::misc_bitwise_and_imm) ? instr_in.imm : m;
		cin     = (instr_in.misc == mexec_pkg::misc_add_with_spill_to_accum ||
			instr_in.misc == mexec_pkg::misc_add_with_spill_to_mem) ? fl_q.spill : 1'b0;
		and_sel = (instr_in.misc == mexec_pkg::misc_bitwise_and_to_accum ||
			instr_in.misc == mexec_pkg::misc_bitwise_and_to_mem ||
			instr_in.misc == mexec_pkg::misc_bitwise_and_imm);
	end

	// ************************************************
	// execute
	// ************************************************
	always_comb begin
		state_d = state_q;
		acc_d   = acc_q;
		th_d    = th_q;
		fl_d    = fl_q;
		to_d    = to_q;
		pd_d    = pd_q;
		pre1_d  = pre1_q;
		pre2_d  = pre2_q;
		ins_d   = ins_q;
		wr_d    = '0;
		wdc_d   = 1'b0;
		pdn_d   = 1'b0;
		skip_d  = 1'b0;
		pcl_d   = 1'b0;
		wr_acc  = 1'b0;
		wr_mem  = 1'b0;
		res     = m;
		// expiry is a timer event; it sets the flag unless a clear lands now
		if (wdt_sync2_q && !wdt_prev_q) begin
			to_d = 1'b1;
		end
		case (state_q)
			st_run: begin
				if (take_issue) begin
					ins_d = instr_in;
					// any instruction clears the pending pre-clear pairing
					pre1_d = 1'b0;
					pre2_d = 1'b0;
					case (instr_in.op)
						mexec_pkg::increment_to_accumulator, mexec_pkg::increment_to_mem: begin
							res = m + `MEXEC_BYTE_ONE;
							fl_d.null_flag = (res == `MEXEC_BYTE_ZERO);
							wr_acc = (instr_in.op == mexec_pkg::increment_to_accumulator);
							wr_mem = !wr_acc;
						end
						mexec_pkg::decrement_to_accumulator, mexec_pkg::decrement_to_mem: begin
							res = m - `MEXEC_BYTE_ONE;
							fl_d.null_flag = (res == `MEXEC_BYTE_ZERO);
							wr_acc = (instr_in.op == mexec_pkg::decrement_to_accumulator);
							wr_mem = !wr_acc;
						end
						mexec_pkg::rotate_right_to_accum, mexec_pkg::rotate_right_to_mem: begin
							res = {m[0], m[7:1]};
							wr_acc = (instr_in.op == mexec_pkg::rotate_right_to_accum);
							wr_mem = !wr_acc;
						end
						mexec_pkg::rotate_left_to_accum, mexec_pkg::rotate_left_to_mem: begin
							res = {m[6:0], m[7]};
							wr_acc = (instr_in.op == mexec_pkg::rotate_left_to_accum);
							wr_mem = !wr_acc;
						end
						mexec_pkg::rotate_right_thru_spill_accum,
						mexec_pkg::rotate_right_thru_spill: begin
							res = {fl_q.spill, m[7:1]};
							fl_d.spill = m[0];
							wr_acc = (instr_in.op == mexec_pkg::rotate_right_thru_spill_accum);
							wr_mem = !wr_acc;
						end
						mexec_pkg::rotate_left_thru_spill_accum,
						mexec_pkg::rotate_left_thru_spill: begin
							res = {m[6:0], fl_q.spill};
							fl_d.spill = m[7];
							wr_acc = (instr_in.op == mexec_pkg::rotate_left_thru_spill_accum);
							wr_mem = !wr_acc;
						end
						mexec_pkg::move_mem_to_accum: begin
							wr_acc = 1'b1;
						end
						mexec_pkg::move_imm_to_accum: begin
							res = instr_in.imm;
							wr_acc = 1'b1;
						end
						mexec_pkg::move_accum_to_mem: begin
							res = acc_q;
							wr_mem = 1'b1;
						end
						mexec_pkg::bit_clear: begin
							res[instr_in.bit_sel] = 1'b0;
							wr_mem = 1'b1;
						end
						mexec_pkg::bit_set: begin
							res[instr_in.bit_sel] = 1'b1;
							wr_mem = 1'b1;
						end
						mexec_pkg::skip_if_null: begin
							skip_d = (m == `MEXEC_BYTE_ZERO);
						end
						mexec_pkg::skip_null_copy_accum: begin
							wr_acc = 1'b1;
							skip_d = (m == `MEXEC_BYTE_ZERO);
						end
						mexec_pkg::skip_if_bit_clear: begin
							skip_d = !m[instr_in.bit_sel];
						end
						mexec_pkg::skip_if_bit_set: begin
							skip_d = m[instr_in.bit_sel];
						end
						mexec_pkg::inc_skip_if_null, mexec_pkg::inc_skip_null_accum: begin
							res = m + `MEXEC_BYTE_ONE;
							skip_d = (res == `MEXEC_BYTE_ZERO);
							wr_acc = (instr_in.op == mexec_pkg::inc_skip_null_accum);
							wr_mem = !wr_acc;
						end
						mexec_pkg::dec_skip_if_null, mexec_pkg::dec_skip_null_accum: begin
							res = m - `MEXEC_BYTE_ONE;
							skip_d = (res == `MEXEC_BYTE_ZERO);
							wr_acc = (instr_in.op == mexec_pkg::dec_skip_null_accum);
							wr_mem = !wr_acc;
						end
						mexec_pkg::jump_direct, mexec_pkg::call_sub, mexec_pkg::ret_sub,
						mexec_pkg::return_from_irq: begin
							state_d = st_second;
						end
						mexec_pkg::ret_load_imm: begin
							res = instr_in.imm;
							wr_acc = 1'b1;
							state_d = st_second;
						end
						mexec_pkg::op_misc: begin
							case (instr_in.misc)
								mexec_pkg::misc_lookup_read_cur_page,
								mexec_pkg::misc_lookup_read_last_page: begin
									res = prog_data_in[7:0];
									th_d = prog_data_in[15:8];
									wr_mem = 1'b1;
									state_d = st_second;
								end
								mexec_pkg::misc_nibble_exchange_mem,
								mexec_pkg::misc_nibble_exchange_accum: begin
									res = {m[3:0], m[7:4]};
									wr_acc = (instr_in.misc == mexec_pkg::misc_nibble_exchange_accum);
									wr_mem = !wr_acc;
								end
								mexec_pkg::misc_watchdog_clear: begin
									to_d = 1'b0;
									pd_d = 1'b0;
									wdc_d = 1'b1;
								end
								mexec_pkg::misc_watchdog_preclear_first: begin
									// the pair completes only right after the second one
									if (pre2_q) begin
										to_d = 1'b0;
										pd_d = 1'b0;
										wdc_d = 1'b1;
									end else begin
										pre1_d = 1'b1;
									end
								end
								mexec_pkg::misc_watchdog_preclear_second: begin
									if (pre1_q) begin
										to_d = 1'b0;
										pd_d = 1'b0;
										wdc_d = 1'b1;
									end else begin
										pre2_d = 1'b1;
									end
								end
								mexec_pkg::misc_power_down: begin
									to_d = 1'b0;
									pd_d = 1'b1;
									wdc_d = 1'b1;
									pdn_d = 1'b1;
									state_d = st_halted;
								end
								mexec_pkg::misc_bitwise_and_to_accum,
								mexec_pkg::misc_bitwise_and_imm,
								mexec_pkg::misc_bitwise_and_to_mem: begin
									res = alu_res;
									fl_d.null_flag = alu_fl.null_flag;
									wr_mem = (instr_in.misc == mexec_pkg::misc_bitwise_and_to_mem);
									wr_acc = !wr_mem;
								end
								default: begin
									// the five add forms
									res = alu_res;
									fl_d = alu_fl;
									wr_mem = (instr_in.misc == mexec_pkg::misc_add_with_spill_to_mem ||
										instr_in.misc == mexec_pkg::misc_add_to_mem);
									wr_acc = !wr_mem;
								end
							endcase
						end
						default: begin
						end
					endcase
					if (wr_acc) begin
						acc_d = res;
					end
					wr_d.we   = wr_mem;
					wr_d.addr = instr_in.mem_addr;
					wr_d.data = res;
					if (skip_d) begin
						state_d = st_second;
					end
					// a program counter low write costs a refetch cycle
					if (wr_mem && instr_in.mem_addr == `MEXEC_PC_LOW_ADDR) begin
						pcl_d = 1'b1;
						state_d = st_second;
					end
				end
			end
			st_second: begin
				state_d = st_run;
			end
			st_halted: begin
				// only reset leaves power-down; the system clock is gated outside
				state_d = st_halted;
			end
			default: begin
				state_d = st_run;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_q     <= st_run;
			acc_q       <= `MEXEC_ACC_RST;
			th_q        <= `MEXEC_TH_RST;
			fl_q        <= '0;
			to_q        <= 1'b0;
			pd_q        <= 1'b0;
			pre1_q      <= 1'b0;
			pre2_q      <= 1'b0;
			ins_q       <= '0;
			wr_q        <= '0;
			wdc_q       <= 1'b0;
			pdn_q       <= 1'b0;
			skip_q      <= 1'b0;
			pcl_q       <= 1'b0;
			wdt_sync1_q <= 1'b0;
			wdt_sync2_q <= 1'b0;
			wdt_prev_q  <= 1'b0;
		end else begin
			state_q     <= state_d;
			acc_q       <= acc_d;
			th_q        <= th_d;
			fl_q        <= fl_d;
			to_q        <= to_d;
			pd_q        <= pd_d;
			pre1_q      <= pre1_d;
			pre2_q      <= pre2_d;
			ins_q       <= ins_d;
			wr_q        <= wr_d;
			wdc_q       <= wdc_d;
			pdn_q       <= pdn_d;
			skip_q      <= skip_d;
			pcl_q       <= pcl_d;
			wdt_sync1_q <= wdt_expire_in;
			wdt_sync2_q <= wdt_sync1_q;
			wdt_prev_q  <= wdt_sync2_q;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign mem_wr_out             = wr_q;
	assign acc_out                = acc_q;
	assign lookup_high_byte_out   = th_q;
	assign flags_out              = fl_q;
	assign wdt_expired_flag_out   = to_q;
	assign sleep_entered_flag_out = pd_q;
	assign wdt_clear_out          = wdc_q;
	assign power_down_out         = pdn_q;
	assign skip_next_out          = skip_q;
	assign pc_load_out            = pcl_q;

endmodule

// *** mexec_core_chk.sv ***
// properties of the execution core
`timescale 1ns/1ps
`include "mexec_params.svh"

module mexec_core_chk (
	// clock and reset
	input wire logic                clock_in,
	input wire logic                rst_in,
	// issue and memory
	input wire logic                instr_valid_in,
	input mexec_pkg::mexec_instr_t  instr_in,
	input wire logic                instr_ready_out,
	input wire logic [7:0]          mem_rdata_in,
	input mexec_pkg::mexec_mem_wr_t mem_wr_out,
	// status
	input wire logic [7:0]          acc_out,
	input mexec_pkg::mexec_flags_t  flags_out,
	input wire logic                wdt_expired_flag_out,
	input wire logic                sleep_entered_flag_out,
	input wire logic                wdt_clear_out,
	input wire logic                power_down_out,
	input wire logic                skip_next_out,
	input wire logic                pc_load_out
);
	wire take = instr_valid_in && instr_ready_out;
	wire misc = take && instr_in.op == mexec_pkg::op_misc;

	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);

	// ****
	// steps
	// ****
	sequence refuse_one;
		!instr_ready_out ##1 instr_ready_out;
	endsequence
	sequence wd_quiet;
		!wdt_expired_flag_out && !sleep_entered_flag_out;
	endsequence

	// ****
	// properties
	// ****
	branch_time_a:
	assert property (take && instr_in.op inside
		{[mexec_pkg::jump_direct:mexec_pkg::return_from_irq]} |=> refuse_one)
		else $error("branch timing");
	skip_time_a:
	assert property (take && instr_in.op inside
		{[mexec_pkg::skip_if_null:mexec_pkg::dec_skip_null_accum]}
		|=> (skip_next_out ##0 refuse_one) or (!skip_next_out && instr_ready_out != pc_load_out))
		else $error("skip timing");
	pcl_time_a:
	assert property (mem_wr_out.we && mem_wr_out.addr == `MEXEC_PC_LOW_ADDR
		|-> pc_load_out ##0 refuse_one)
		else $error("pcl timing");
	inc_mem_a:
	assert property (take && instr_in.op == mexec_pkg::increment_to_mem |=> mem_wr_out.we
		&& mem_wr_out.addr == $past(instr_in.mem_addr)
		&& mem_wr_out.data == $past(mem_rdata_in) + 8'h01
		&& flags_out.null_flag == (mem_wr_out.data == 8'h00) && $stable(flags_out.spill))
		else $error("inc to mem");
	move_acc_a:
	assert property (take && instr_in.op == mexec_pkg::move_mem_to_accum
		|=> acc_out == $past(mem_rdata_in) && $stable(flags_out))
		else $error("move to acc");
	rot_flags_a:
	assert property (take && instr_in.op inside {mexec_pkg::rotate_right_to_accum,
		mexec_pkg::rotate_right_to_mem, mexec_pkg::rotate_left_to_accum,
		mexec_pkg::rotate_left_to_mem} |=> $stable(flags_out))
		else $error("rotate flags");
	rrc_acc_a:
	assert property (take && instr_in.op == mexec_pkg::rotate_right_thru_spill_accum
		|=> acc_out == {$past(flags_out.spill), $past(mem_rdata_in[7:1])}
		&& flags_out.spill == $past(mem_rdata_in[0]) && $stable(flags_out.null_flag))
		else $error("rrc to acc");
	wd_clear_a:
	assert property (misc && instr_in.misc == mexec_pkg::misc_watchdog_clear
		|=> wd_quiet ##0 (wdt_clear_out && instr_ready_out))
		else $error("wd clear");
	halt_a:
	assert property (misc && instr_in.misc == mexec_pkg::misc_power_down
		|=> sleep_entered_flag_out && !wdt_expired_flag_out && power_down_out
		&& wdt_clear_out && !instr_ready_out ##1 !instr_ready_out [*3])
		else $error("halt");
	and_imm_a:
	assert property (misc && instr_in.misc == mexec_pkg::misc_bitwise_and_imm
		|=> acc_out == ($past(acc_out) & $past(instr_in.imm))
		&& flags_out.null_flag == (acc_out == 8'h00) && $stable(flags_out.spill))
		else $error("and imm");
endmodule

bind mexec_core mexec_core_chk i_chk (.*);

// *** tb.sv ***
// bench for the execution core
`timescale 1ns/1ps
`include "mexec_params.svh"

module tb;
	typedef struct packed {
		logic [7:0]              a;
		mexec_pkg::mexec_flags_t f;
		logic                    t, p, w, s;
		logic [7:0]              d, h;
	} mexec_exp_t;

	logic                     clock_in = 1'h0, rst_in = 1'h1, instr_valid_in = 1'h0;
	logic                     wdt_expire_in = 1'h0, took = 1'h0;
	mexec_pkg::mexec_instr_t  instr_in = '0;
	logic [7:0]               mem_rdata_in = 8'h00, tbl_ptr_in = 8'h00;
	logic [10:0]              pc_in = 11'h5a3, prog_addr_out;
	logic [15:0]              prog_data_in;
	logic [6:0]               mem_raddr_out;
	mexec_pkg::mexec_mem_wr_t mem_wr_out;
	logic [7:0]               acc_out, lookup_high_byte_out, a_m = 8'h00, h_m = 8'h00;
	mexec_pkg::mexec_flags_t  flags_out, f_m = '0;
	logic                     instr_ready_out, wdt_expired_flag_out, sleep_entered_flag_out;
	logic                     wdt_clear_out, power_down_out, skip_next_out, pc_load_out;
	logic                     t_m = 1'h0, p_m = 1'h0;
	int                       lp = -1, n_fail = 0, tests_run = 0;
	mexec_exp_t               q[$], e_x, e_g;

	// table word: pointer code high, page low
	assign prog_data_in = {prog_addr_out[7:0] ^ 8'h5a, 5'h00, prog_addr_out[10:8]};

	mexec_core i_dut (.clock_in, .rst_in, .instr_valid_in, .instr_in, .instr_ready_out,
		.mem_raddr_out, .mem_rdata_in, .mem_wr_out, .pc_in, .tbl_ptr_in, .prog_addr_out,
		.prog_data_in, .wdt_expire_in, .acc_out, .lookup_high_byte_out, .flags_out,
		.wdt_expired_flag_out, .sleep_entered_flag_out, .wdt_clear_out, .power_down_out,
		.skip_next_out, .pc_load_out);

	always #20 clock_in = !clock_in;

	// ****
	// model
	// ****
	function automatic logic [7:0] add(logic [7:0] p, logic [7:0] v, logic ci);
		logic [8:0] s;
		s = 9'h000 + p + v + ci;
		f_m.half_spill_bit = (5'h00 + p[3:0] + v[3:0] + ci) > 5'h0f;
		f_m.spill = s[8];
		f_m.signed_range_flag = (p[7] == v[7]) && (s[7] != p[7]);
		f_m.null_flag = s[7:0] == 8'h00;
		return s[7:0];
	endfunction

	function automatic logic [7:0] andz(logic [7:0] v);
		f_m.null_flag = (a_m & v) == 8'h00;
		return a_m & v;
	endfunction

	task automatic issue(mexec_pkg::mexec_op_t o, mexec_pkg::mexec_misc_t c,
			logic [7:0] m, logic [7:0] x, logic [6:0] ad);
		logic [7:0] r;
		logic [2:0] b;
		logic       w, k, lo, two;
		b = 3'($urandom);
		r = m;
		k = 1'h0;
		case (o)
			mexec_pkg::increment_to_accumulator, mexec_pkg::increment_to_mem,
			mexec_pkg::inc_skip_if_null, mexec_pkg::inc_skip_null_accum: r = m + 8'h01;
			mexec_pkg::decrement_to_accumulator, mexec_pkg::decrement_to_mem,
			mexec_pkg::dec_skip_if_null, mexec_pkg::dec_skip_null_accum: r = m - 8'h01;
			mexec_pkg::rotate_right_to_accum, mexec_pkg::rotate_right_to_mem: r = {m[0], m[7:1]};
			mexec_pkg::rotate_left_to_accum, mexec_pkg::rotate_left_to_mem: r = {m[6:0], m[7]};
			mexec_pkg::rotate_right_thru_spill_accum, mexec_pkg::rotate_right_thru_spill: begin
				r = {f_m.spill, m[7:1]};
				f_m.spill = m[0];
			end
			mexec_pkg::rotate_left_thru_spill_accum, mexec_pkg::rotate_left_thru_spill: begin
				r = {m[6:0], f_m.spill};
				f_m.spill = m[7];
			end
			mexec_pkg::move_accum_to_mem: r = a_m;
			mexec_pkg::move_imm_to_accum, mexec_pkg::ret_load_imm: r = x;
			mexec_pkg::bit_clear: r[b] = 1'h0;
			mexec_pkg::bit_set: r[b] = 1'h1;
			default: ;
		endcase
		// odd codes up to the immediate move write the accumulator
		lo = o inside {[mexec_pkg::increment_to_accumulator:mexec_pkg::move_imm_to_accum]};
		w = lo ? !o[0] : o inside {mexec_pkg::bit_clear, mexec_pkg::bit_set,
			mexec_pkg::inc_skip_if_null, mexec_pkg::dec_skip_if_null};
		if (lo ? o[0] : o inside {mexec_pkg::skip_null_copy_accum, mexec_pkg::ret_load_imm,
			mexec_pkg::inc_skip_null_accum, mexec_pkg::dec_skip_null_accum})
			a_m = r;
		if (o inside {[mexec_pkg::increment_to_accumulator:mexec_pkg::decrement_to_mem]})
			f_m.null_flag = r == 8'h00;
		if (o inside {[mexec_pkg::skip_if_null:mexec_pkg::dec_skip_null_accum]})
			k = r == 8'h00;
		if (o == mexec_pkg::skip_if_bit_clear)
			k = !m[b];
		if (o == mexec_pkg::skip_if_bit_set)
			k = m[b];
		if (o == mexec_pkg::op_misc) case (c)
			mexec_pkg::misc_lookup_read_cur_page, mexec_pkg::misc_lookup_read_last_page: begin
				r = c[0] ? 8'h07 : {5'h00, pc_in[10:8]};
				h_m = x ^ 8'h5a;
				w = 1'h1;
			end
			mexec_pkg::misc_nibble_exchange_mem: {w, r} = {1'h1, m[3:0], m[7:4]};
			mexec_pkg::misc_nibble_exchange_accum: a_m = {m[3:0], m[7:4]};
			mexec_pkg::misc_watchdog_clear: {t_m, p_m} = 2'h0;
			mexec_pkg::misc_power_down: {t_m, p_m} = 2'h1;
			mexec_pkg::misc_add_with_spill_to_accum: a_m = add(a_m, m, f_m.spill);
			mexec_pkg::misc_add_with_spill_to_mem: {w, r} = {1'h1, add(a_m, m, f_m.spill)};
			mexec_pkg::misc_add_to_accum: a_m = add(a_m, m, 1'h0);
			mexec_pkg::misc_add_to_mem: {w, r} = {1'h1, add(a_m, m, 1'h0)};
			mexec_pkg::misc_add_imm: a_m = add(a_m, x, 1'h0);
			mexec_pkg::misc_bitwise_and_to_accum: a_m = andz(m);
			mexec_pkg::misc_bitwise_and_to_mem: {w, r} = {1'h1, andz(m)};
			mexec_pkg::misc_bitwise_and_imm: a_m = andz(x);
			default: ;
		endcase
		if (o == mexec_pkg::op_misc && c inside {[mexec_pkg::misc_watchdog_preclear_first:
			mexec_pkg::misc_watchdog_preclear_second]}) begin
			if (lp >= 0 && lp != int'(c))
				{t_m, p_m} = 2'h0;
			lp = int'(c);
		end else
			lp = -1;
		two = k || (w && ad == `MEXEC_PC_LOW_ADDR)
			|| o inside {[mexec_pkg::jump_direct:mexec_pkg::return_from_irq]}
			|| (o == mexec_pkg::op_misc && c < mexec_pkg::misc_nibble_exchange_mem);
		q.push_back({a_m, f_m, t_m, p_m, w, k, w ? r : 8'h00, h_m});
		instr_valid_in <= 1'h1;
		instr_in <= {o, c, b, ad, x};
		mem_rdata_in <= m;
		tbl_ptr_in <= x;
		@(posedge clock_in);
		if (two) begin
			instr_valid_in <= 1'h0;
			@(posedge clock_in);
		end
	endtask

	task automatic iss(mexec_pkg::mexec_op_t o, logic [7:0] m, logic [7:0] x);
		issue(o, mexec_pkg::misc_lookup_read_cur_page, m, x, 7'h10);
	endtask

	task automatic msc(mexec_pkg::mexec_misc_t c, logic [7:0] m, logic [7:0] x);
		issue(mexec_pkg::op_misc, c, m, x, 7'h11);
	endtask

	task automatic idle(int n);
		instr_valid_in <= 1'h0;
		repeat (n) @(posedge clock_in);
	endtask

	// ****
	// checks
	// ****
	task automatic chk(mexec_exp_t x, mexec_exp_t g);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t exp %h got %h", $time, x, g);
		end
	endtask

	task automatic complete_run();
		$display("run %0d fail %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(negedge clock_in) took <= instr_valid_in && instr_ready_out && !rst_in;

	always @(negedge clock_in) if (took === 1'h1) begin
		e_g = {acc_out, flags_out, wdt_expired_flag_out, sleep_entered_flag_out, mem_wr_out.we,
			skip_next_out, mem_wr_out.we ? mem_wr_out.data : 8'h00, lookup_high_byte_out};
		if (q.size() == 0)
			n_fail++;
		else begin
			e_x = q.pop_front();
			chk(e_x, e_g);
		end
	end

	initial begin
		#100000;
		n_fail++;
		complete_run();
	end

	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(35));
		repeat (3) @(posedge clock_in);
		rst_in <= 1'h0;
		iss(mexec_pkg::move_imm_to_accum, 8'h00, 8'h7f);
		msc(mexec_pkg::misc_add_imm, 8'h00, 8'h01);
		msc(mexec_pkg::misc_add_with_spill_to_mem, 8'h80, 8'h00);
		msc(mexec_pkg::misc_add_with_spill_to_accum, 8'h7f, 8'h00);
		iss(mexec_pkg::increment_to_mem, 8'hff, 8'h00);
		iss(mexec_pkg::decrement_to_accumulator, 8'h01, 8'h00);
		iss(mexec_pkg::inc_skip_if_null, 8'hff, 8'h00);
		iss(mexec_pkg::dec_skip_null_accum, 8'h02, 8'h00);
		iss(mexec_pkg::skip_if_null, 8'h00, 8'h00);
		for (int i = 26; i <= 30; i++)
			iss(mexec_pkg::mexec_op_t'(i), 8'h00, 8'h3c);
		msc(mexec_pkg::misc_lookup_read_cur_page, 8'h00, 8'h96);
		msc(mexec_pkg::misc_lookup_read_last_page, 8'h00, 8'h2e);
		issue(mexec_pkg::move_accum_to_mem, mexec_pkg::misc_add_imm, 8'h00, 8'h00,
			`MEXEC_PC_LOW_ADDR);
		msc(mexec_pkg::misc_nibble_exchange_accum, 8'ha5, 8'h00);
		for (int i = 0; i < 60; i++)
			issue(i % 3 ? mexec_pkg::mexec_op_t'($urandom_range(25, 1)) : mexec_pkg::op_misc,
				mexec_pkg::mexec_misc_t'($urandom_range(15, 8)), 8'($urandom), 8'($urandom),
				7'($urandom));
		wdt_expire_in <= 1'h1;
		idle(6);
		t_m = 1'h1;
		msc(mexec_pkg::misc_watchdog_preclear_first, 8'h00, 8'h00);
		msc(mexec_pkg::misc_watchdog_preclear_first, 8'h00, 8'h00);
		iss(mexec_pkg::op_nop, 8'h00, 8'h00);
		msc(mexec_pkg::misc_watchdog_preclear_second, 8'h00, 8'h00);
		iss(mexec_pkg::op_nop, 8'h00, 8'h00);
		msc(mexec_pkg::misc_watchdog_preclear_first, 8'h00, 8'h00);
		msc(mexec_pkg::misc_watchdog_preclear_second, 8'h00, 8'h00);
		wdt_expire_in <= 1'h0;
		idle(3);
		wdt_expire_in <= 1'h1;
		idle(6);
		t_m = 1'h1;
		msc(mexec_pkg::misc_watchdog_clear, 8'h00, 8'h00);
		msc(mexec_pkg::misc_power_down, 8'h00, 8'h00);
		idle(5);
		if (q.size() != 0)
			n_fail++;
		complete_run();
	end
endmodule
